// file: hdl/sbtc_pkg.sv
// Constants shared by the sixteen bit timer/counter design files.
// Assumes a 10 MHz system clock and a classic Wishbone register bus.
package sbtc_pkg;
   // Printed register offsets, kept as word indices; byte address is four times these.
   localparam logic [9:0]  SBTC_IDX_FLAGS   = 10'h00C;
   localparam logic [9:0]  SBTC_IDX_CNT_LO  = 10'h00E;
   localparam logic [9:0]  SBTC_IDX_CNT_HI  = 10'h00F;
   localparam logic [9:0]  SBTC_IDX_CTRL    = 10'h010;
   localparam logic [9:0]  SBTC_IDX_ENABLES = 10'h08C;
   // Control and flag register field positions.
   localparam int          SBTC_BIT_RUN     = 0;
   localparam int          SBTC_BIT_SRC     = 1;
   localparam int          SBTC_BIT_NOSYNC  = 2;
   localparam int          SBTC_BIT_OSCEN   = 3;
   localparam int          SBTC_BIT_PS_LO   = 4;
   localparam int          SBTC_BIT_OVF     = 0;
   localparam logic [7:0]  SBTC_CTRL_MASK   = 8'h3F;
   localparam logic [7:0]  SBTC_CTRL_RESET  = 8'h00;
   localparam logic        SBTC_FLAG_RESET  = 1'h0;
   // Internal clock is the system clock divided by four.
   localparam int          SBTC_SYS_DIV     = 4;
   localparam logic [1:0]  SBTC_DIV_LAST    = 2'(SBTC_SYS_DIV - 1);
   localparam logic [15:0] SBTC_CNT_MAX     = 16'hFFFF;
   localparam int          SBTC_SYNC_STAGES = 2;
endpackage : sbtc_pkg

// file: hdl/sbtc_prescaler.sv
// Input prescaler dividing a stream of one-cycle ticks by 1, 2, 4 or 8.
// Assumes ticks and clear are synchronous to the system clock.
`timescale 1ns/1ns
`default_nettype none
module sbtc_prescaler
   import sbtc_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       sys_rst_in,
   input  wire logic       clear_in,
   input  wire logic [1:0] ratio_in,
   input  wire logic       tick_in,
   output logic            tick_out
);
   logic [2:0] cnt_r;
   logic [2:0] last;

   assign last = 3'((1 << ratio_in) - 1);
   assign tick_out = tick_in && (cnt_r == last);

   // Counter restarts on a clear and whenever the divided tick leaves.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in || clear_in) begin
         cnt_r <= 3'h0;
      end else if (tick_in) begin
         cnt_r <= (cnt_r == last) ? 3'h0 : 3'(cnt_r + 3'h1);
      end
   end
endmodule : sbtc_prescaler
`default_nettype wire

// file: hdl/sbtc_edge_gate.sv
// Rising edge detector for the external count input with a falling-edge arm.
// Assumes the pin level is already synchronous to the system clock.
`timescale 1ns/1ns
`default_nettype none
module sbtc_edge_gate
   import sbtc_pkg::*;
(
   input  wire logic clock_in,
   input  wire logic sys_rst_in,
   input  wire logic enable_in,
   input  wire logic level_in,
   output logic      rise_out
);
   logic prev_r;
   logic armed_r;

   assign rise_out = enable_in && armed_r && level_in && !prev_r;

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         prev_r <= 1'h0;
      end else begin
         prev_r <= level_in;
      end
   end

   // A falling edge must be seen after enabling before any rise counts.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in || !enable_in) begin
         armed_r <= 1'h0;
      end else if (prev_r && !level_in) begin
         armed_r <= 1'h1;
      end
   end
endmodule : sbtc_edge_gate
`default_nettype wire

// file: hdl/sbtc_timer.sv
// Sixteen bit timer/counter with prescaler, overflow flag and Wishbone registers.
// Assumes one 10 MHz clock, synchronous pin inputs and a classic Wishbone master.
//
// Summary of operation
// - Sixteen bit count in two readable, writable bytes counts up and wraps.
// - Each wrap latches the overflow flag; interrupt passes only when enabled.
// - Control bit 1 selects external rising edges or system clock divided by four.
// - Control bit 0 runs the counter; stopped counter keeps its value.
// - Control bits 5 to 4 select prescale 1:1, 1:2, 1:4 or 1:8.
// - Control bit 3 turns the low-power oscillator on; off saves power.
// - Oscillator enabled forces both its pins to inputs reading as zero.
// - Control bit 2 disables synchronisation, only when external source is selected.
// - After enabling external counting, one falling edge precedes the first count.
// - Counter mode takes edges from oscillator pin or clock pin per bit 3.
// - Synchronised mode resynchronises the prescaler output, not the raw input.
// - Synchronised mode in sleep: count halts, prescaler keeps counting.
// - Unsynchronised mode keeps counting in sleep and may raise the interrupt.
// - Unsynchronised mode offers no time base to capture/compare units.
// - Either capture/compare unit may reset the count, except in unsynchronised mode.
// - Control bits 7 and 6 always read as zero.
// - Writing either count byte clears the prescaler.
// - A count write wins over a simultaneous compare reset.
// - Power-on reset clears control; other resets leave it unchanged.
// - No reset clears the count; only the compare trigger does.
`timescale 1ns/1ns
`default_nettype none
module sbtc_timer
   import sbtc_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        sys_rst_in,
   input  wire logic        other_rst_in,
   input  wire logic        sleep_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [11:0] wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic [31:0]      wb_dat_out,
   output logic             wb_ack_out,
   input  wire logic        osc_in_pin_in,
   input  wire logic        ext_clock_pin_in,
   input  wire logic [1:0]  port_direction_in,
   output logic [1:0]       pin_oe_out,
   output logic [1:0]       pin_read_out,
   output logic             osc_enable_out,
   input  wire logic        ccp1_reset_in,
   input  wire logic        ccp2_reset_in,
   output logic             irq_out,
   output logic [15:0]      time_base_out,
   output logic             time_base_valid_out
);
   logic [7:0]  timer_control_r;
   logic [15:0] count_r;
   logic        overflow_flag_r;
   logic        overflow_irq_enable_r;
   logic        ack_r;
   logic [31:0] rdata_r;
   logic [1:0]  div_r;
   logic [SBTC_SYNC_STAGES-1:0] sync_r;

   logic        run_bit;
   logic        source_select;
   logic        sync_disable;
   logic        osc_enable;
   logic [1:0]  prescale_field;
   logic        req;
   logic        wr;
   logic [9:0]  idx;
   logic        wr_lo;
   logic        wr_hi;
   logic        int_tick;
   logic        ext_level;
   logic        ext_rise;
   logic        pre_in;
   logic        pre_out;
   logic        cnt_tick;
   logic        ccp_reset;
   logic        wrap;

   // Decodes a word index from a Wishbone byte address.
   function automatic logic hit(input logic [11:0] adr, input logic [9:0] index);
      hit = (adr[11:2] == index) && (adr[1:0] == 2'h0);
   endfunction : hit

   assign run_bit        = timer_control_r[SBTC_BIT_RUN];
   assign source_select  = timer_control_r[SBTC_BIT_SRC];
   assign sync_disable   = timer_control_r[SBTC_BIT_NOSYNC];
   assign osc_enable     = timer_control_r[SBTC_BIT_OSCEN];
   assign prescale_field = timer_control_r[SBTC_BIT_PS_LO +: 2];

   assign req   = wb_cyc_in && wb_stb_in && !ack_r;
   assign wr    = req && wb_we_in && wb_sel_in[0];
   assign idx   = wb_adr_in[11:2];
   assign wr_lo = wr && hit(wb_adr_in, SBTC_IDX_CNT_LO);
   assign wr_hi = wr && hit(wb_adr_in, SBTC_IDX_CNT_HI);

   assign wb_ack_out = ack_r;
   assign wb_dat_out = rdata_r;

   // Oscillator pins become inputs and read zero while it runs.
   assign osc_enable_out = osc_enable;
   assign pin_oe_out     = osc_enable ? 2'h0 : ~port_direction_in;
   assign pin_read_out   = osc_enable ? 2'h0 :
                           {osc_in_pin_in, ext_clock_pin_in};

   // Oscillator pin feeds the counter when enabled, else the clock pin.
   assign ext_level = osc_enable ? osc_in_pin_in : ext_clock_pin_in;

   // Internal tick stops during sleep since the core clock halts.
   assign int_tick = (div_r == SBTC_DIV_LAST) && !sleep_in;

   sbtc_edge_gate u_edge (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in || other_rst_in),
      .enable_in  (run_bit && source_select),
      .level_in   (ext_level),
      .rise_out   (ext_rise)
   );

   // Source select chooses external edges or the internal tick.
   assign pre_in = run_bit && (source_select ? ext_rise : int_tick);

   sbtc_prescaler u_pre (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in || other_rst_in),
      .clear_in   (wr_lo || wr_hi),
      .ratio_in   (prescale_field),
      .tick_in    (pre_in),
      .tick_out   (pre_out)
   );

   // Synchroniser after the prescaler; a shift of pulses, halted in sleep.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in || other_rst_in) begin
         sync_r <= '0;
      end else if (!sleep_in) begin
         sync_r <= {sync_r[SBTC_SYNC_STAGES-2:0], pre_out};
      end
   end

   // Sync bit only matters for the external source.
   always_comb begin
      if (!source_select) begin
         cnt_tick = pre_out;
      end else if (sync_disable) begin
         cnt_tick = pre_out;
      end else begin
         cnt_tick = sync_r[SBTC_SYNC_STAGES-1] && !sleep_in;
      end
   end

   assign ccp_reset = (ccp1_reset_in || ccp2_reset_in) &&
                      !(source_select && sync_disable);
   assign wrap      = cnt_tick && (count_r == SBTC_CNT_MAX);

   // Count has no reset; writes beat compare resets, which beat counting.
   always_ff @(posedge clock_in) begin
      if (wr_lo || wr_hi) begin
         if (wr_lo) begin
            count_r[7:0] <= wb_dat_in[7:0];
         end
         if (wr_hi) begin
            count_r[15:8] <= wb_dat_in[7:0];
         end
      end else if (ccp_reset) begin
         count_r <= 16'h0000;
      end else if (cnt_tick) begin
         count_r <= 16'(count_r + 16'h0001);
      end
   end

   // Only the power-on reset clears the control register.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         timer_control_r <= SBTC_CTRL_RESET;
      end else if (wr && hit(wb_adr_in, SBTC_IDX_CTRL)) begin
         timer_control_r <= wb_dat_in[7:0] & SBTC_CTRL_MASK;
      end
   end

   // Overflow flag: a wrap in the same cycle as a software clear wins.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in || other_rst_in) begin
         overflow_flag_r <= SBTC_FLAG_RESET;
      end else if (wrap) begin
         overflow_flag_r <= 1'h1;
      end else if (wr && hit(wb_adr_in, SBTC_IDX_FLAGS)) begin
         overflow_flag_r <= wb_dat_in[SBTC_BIT_OVF];
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in || other_rst_in) begin
         overflow_irq_enable_r <= SBTC_FLAG_RESET;
      end else if (wr && hit(wb_adr_in, SBTC_IDX_ENABLES)) begin
         overflow_irq_enable_r <= wb_dat_in[SBTC_BIT_OVF];
      end
   end

   assign irq_out = overflow_flag_r && overflow_irq_enable_r;

   // Time base is withheld from capture/compare in unsynchronised mode.
   assign time_base_valid_out = !(source_select && sync_disable);
   assign time_base_out       = time_base_valid_out ? count_r : 16'h0000;

   // Divide-by-four phase counter for the internal source.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in || other_rst_in) begin
         div_r <= 2'h0;
      end else if (!sleep_in) begin
         div_r <= 2'(div_r + 2'h1);
      end
   end

   // One wait state; unmapped addresses answer with zero data.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         ack_r   <= 1'h0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ack_r   <= req;
         rdata_r <= 32'h0000_0000;
         if (req && !wb_we_in) begin
            unique case (idx)
               SBTC_IDX_CNT_LO:  rdata_r[7:0] <= count_r[7:0];
               SBTC_IDX_CNT_HI:  rdata_r[7:0] <= count_r[15:8];
               SBTC_IDX_CTRL:    rdata_r[7:0] <= timer_control_r;
               SBTC_IDX_FLAGS:   rdata_r[SBTC_BIT_OVF] <= overflow_flag_r;
               SBTC_IDX_ENABLES: rdata_r[SBTC_BIT_OVF] <= overflow_irq_enable_r;
               default:          rdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule : sbtc_timer
`default_nettype wire

// file: verification/sbtc_timer_monitor.sv
// Concurrent checks on the timer's bus, pin and time base outputs.
// Assumes it is bound to every instance of sbtc_timer.
`timescale 1ns/1ns
`default_nettype none
module sbtc_timer_monitor (
   input wire logic        clock_in,
   input wire logic        sys_rst_in,
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic        wb_ack_out,
   input wire logic [1:0]  port_direction_in,
   input wire logic        osc_in_pin_in,
   input wire logic        ext_clock_pin_in,
   input wire logic [1:0]  pin_oe_out,
   input wire logic [1:0]  pin_read_out,
   input wire logic        osc_enable_out,
   input wire logic        irq_out,
   input wire logic [15:0] time_base_out,
   input wire logic        time_base_valid_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   a_ack_answers: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("no ack after request");
   a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   a_ack_caused: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
      else $error("ack without request");
   a_rd_idle_zero: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
      else $error("read data outside answer");
   a_rd_upper_zero: assert property (wb_dat_out[31:8] == 24'h0)
      else $error("upper read bits set");
   a_osc_pins_input: assert property (osc_enable_out |-> pin_oe_out == 2'h0 && pin_read_out == 2'h0)
      else $error("oscillator pins not forced");
   a_pins_follow_port: assert property (!osc_enable_out |-> pin_oe_out == ~port_direction_in
      && pin_read_out == {osc_in_pin_in, ext_clock_pin_in}) else $error("pin path wrong");
   a_async_no_base: assert property (!time_base_valid_out |-> time_base_out == 16'h0)
      else $error("time base offered while invalid");
   a_ctrl_cleared: assert property ($fell(sys_rst_in) |-> !osc_enable_out && !irq_out)
      else $error("control not cleared by reset");
   cover property (wb_ack_out && wb_dat_out[0]);
   cover property (irq_out);
   cover property (!time_base_valid_out);
endmodule : sbtc_timer_monitor
bind sbtc_timer sbtc_timer_monitor mon_u (.clock_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in,
   .wb_dat_out, .wb_ack_out, .port_direction_in, .osc_in_pin_in, .ext_clock_pin_in, .pin_oe_out,
   .pin_read_out, .osc_enable_out, .irq_out, .time_base_out, .time_base_valid_out);
`default_nettype wire

// file: verification/sbtc_clk_src.sv
// External count source: a burst of pulses on the oscillator or the clock pin.
// Assumes pins are sampled on the system clock; both pins rest low between bursts.
`timescale 1ns/1ns
`default_nettype none
module sbtc_clk_src #(
   parameter int HALF = 4
) (
   input  wire logic       clock_in,
   input  wire logic       start_in,
   input  wire logic [7:0] rises_in,
   input  wire logic       sel_in,
   output logic            osc_pin_out,
   output logic            ext_pin_out,
   output logic            busy_out
);
   logic lvl  = 1'b0;
   int   left = 0;
   int   ph   = 0;
   always_ff @(posedge clock_in) begin
      if (start_in) begin
         left <= int'(rises_in);
         ph   <= 0;
         lvl  <= 1'b0;
      end else if (left != 0) begin
         ph <= (ph == HALF - 1) ? 0 : ph + 1;
         if (ph == HALF - 1) begin
            lvl  <= ~lvl;
            left <= lvl ? left - 1 : left;
         end
      end
   end
   assign osc_pin_out = sel_in & lvl;
   assign ext_pin_out = ~sel_in & lvl;
   assign busy_out    = start_in | (left != 0);
endmodule : sbtc_clk_src
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the sixteen bit timer/counter.
// Assumes the monitor is bound by its own file and a 10 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb
   import sbtc_pkg::*;
;
   typedef struct {logic [7:0] ctrl; logic sel; logic slp; logic [7:0] cnt;} sbtc_row_t;
   localparam logic [11:0] A_FLG = {SBTC_IDX_FLAGS, 2'h0};
   localparam logic [11:0] A_LO  = {SBTC_IDX_CNT_LO, 2'h0};
   localparam logic [11:0] A_HI  = {SBTC_IDX_CNT_HI, 2'h0};
   localparam logic [11:0] A_CTL = {SBTC_IDX_CTRL, 2'h0};
   localparam logic [11:0] A_EN  = {SBTC_IDX_ENABLES, 2'h0};
   logic        clock_in = 1'b0, sys_rst_in = 1'b1, other_rst_in = 1'b0, sleep_in = 1'b0;
   logic        wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0, wb_ack_out, irq_out;
   logic [11:0] wb_adr_in = 12'h0;
   logic [31:0] wb_dat_in = 32'h0, wb_dat_out;
   logic        ccp1 = 1'b0, ccp2 = 1'b0, start = 1'b0, sel = 1'b0, osc_pin, ext_pin, busy;
   logic [7:0]  q;
   logic [1:0]  pdir = 2'h2;
   logic [15:0] tbase;
   int          error_cnt = 0, tests_run = 0, cycles = 0, n;
   sbtc_row_t   rows[9] = '{'{8'h03, 0, 0, 8'h10}, '{8'h13, 0, 0, 8'h08},
      '{8'h23, 0, 0, 8'h04}, '{8'h33, 0, 0, 8'h02}, '{8'h07, 0, 1, 8'h10},
      '{8'h0B, 1, 0, 8'h10}, '{8'h03, 1, 0, 8'h00}, '{8'h02, 0, 0, 8'h00}, '{8'h03, 0, 1, 8'h00}};
   sbtc_timer dut_u (.clock_in, .sys_rst_in, .other_rst_in, .sleep_in, .wb_cyc_in, .wb_stb_in,
      .wb_we_in, .wb_adr_in, .wb_sel_in(4'h1), .wb_dat_in, .wb_dat_out, .wb_ack_out,
      .osc_in_pin_in(osc_pin), .ext_clock_pin_in(ext_pin), .port_direction_in(pdir),
      .pin_oe_out(), .pin_read_out(), .osc_enable_out(), .ccp1_reset_in(ccp1),
      .ccp2_reset_in(ccp2), .irq_out, .time_base_out(tbase), .time_base_valid_out());
   sbtc_clk_src src_u (.clock_in, .start_in(start), .rises_in(8'h11), .sel_in(sel),
      .osc_pin_out(osc_pin), .ext_pin_out(ext_pin), .busy_out(busy));
   initial begin
      forever #50 clock_in = ~clock_in;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wb(input logic we, input logic [11:0] adr, input logic [7:0] d);
      @(posedge clock_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in  <= we;
      wb_adr_in <= adr;
      wb_dat_in <= {24'h0, d};
      do @(posedge clock_in); while (wb_ack_out !== 1'b1);
      q = wb_dat_out[7:0];
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask : wb
   task automatic pulse(input int w);
      @(posedge clock_in);
      {ccp2, ccp1, sys_rst_in, other_rst_in, start} <= 5'(1 << w);
      @(posedge clock_in);
      {ccp2, ccp1, sys_rst_in, other_rst_in, start} <= 5'h00;
   endtask : pulse
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      repeat (2) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      foreach (rows[i]) begin
         wb(1, A_CTL, 8'h00);
         wb(1, A_LO, 8'h00);
         wb(1, A_HI, 8'h00);
         sel      <= rows[i].sel;
         sleep_in <= rows[i].slp;
         pdir     <= 2'(i);
         wb(1, A_CTL, rows[i].ctrl);
         pulse(0);
         while (busy === 1'b1) @(posedge clock_in);
         repeat (8) @(posedge clock_in);
         wb(0, A_LO, 8'h00);
         chk(q, rows[i].cnt);
         chk(tbase, (rows[i].ctrl[2:1] == 2'h3) ? 16'h0 : {8'h0, rows[i].cnt});
         wb(0, A_CTL, 8'h00);
         chk(q, rows[i].ctrl);
         sleep_in <= 1'b0;
         $display("row %0d done", i);
      end
      wb(1, A_CTL, 8'hFF);
      wb(0, A_CTL, 8'h00);
      chk(q, 8'h3F);
      pulse(1);
      wb(0, A_CTL, 8'h00);
      chk(q, 8'h3F);
      wb(1, A_LO, 8'hFC);
      wb(1, A_HI, 8'hFF);
      wb(1, A_EN, 8'h01);
      wb(1, A_CTL, 8'h01);
      for (n = 0; n < 40 && irq_out !== 1'b1; n++) @(posedge clock_in);
      chk(16'(n >= 12 && n <= 20), 16'h1);
      wb(1, A_CTL, 8'h00);
      wb(0, A_FLG, 8'h00);
      chk(q, 8'h01);
      wb(1, A_EN, 8'h00);
      chk(irq_out, 1'b0);
      wb(1, A_FLG, 8'h00);
      wb(0, A_FLG, 8'h00);
      chk(q, 8'h00);
      wb(0, 12'h100, 8'h00);
      chk(q, 8'h00);
      $display("timer tests done");
      wb(1, A_LO, 8'h55);
      wb(1, A_CTL, 8'h3C);
      pulse(2);
      wb(0, A_LO, 8'h00);
      chk(q, 8'h55);
      wb(0, A_CTL, 8'h00);
      chk(q, 8'h00);
      pulse(3);
      wb(0, A_LO, 8'h00);
      chk(q, 8'h00);
      wb(1, A_LO, 8'h55);
      pulse(4);
      wb(0, A_LO, 8'h00);
      chk(q, 8'h00);
      fork
         wb(1, A_LO, 8'hAA);
         begin
            @(posedge clock_in);
            ccp1 <= 1'b1;
            @(posedge clock_in);
            ccp1 <= 1'b0;
         end
      join
      wb(0, A_LO, 8'h00);
      chk(q, 8'hAA);
      $display("reset tests done");
      print_verdict();
   end
endmodule : tb
`default_nettype wire
